// ---- src/abx_exec.sv ----
// Execution unit for six instructions with its register file and AXI4-Lite slave.
// Assumes an AXI4-Lite master on ref_clk; one write and one read at a time.
//
// Functional notes
// [RULE1] Add-with-carry sums accumulator, file and carry
// [RULE2] Destination bit zero writes the accumulator
// [RULE3] Destination bit one writes the file register
// [RULE4] Access bit zero uses the access bank
// [RULE5] Access bit one uses the bank pointer
// [RULE6] Extended mode indexes file fields up to 5Fh
// [RULE7] AND-literal writes accumulator AND literal
// [RULE8] AND-file result goes to selected destination
// [RULE9] Branch-if-carry taken only when carry set
// [RULE10] Target is next address plus twice offset
// [RULE11] Taken branch adds a no-operation cycle
// [RULE12] Bit-clear zeroes one bit, flags kept
// [RULE13] Branch-if-negative taken only when negative set
// [RULE14] Each instruction updates only its own flags
// [RULE15] One cycle is decode, read, process, write
`timescale 1ns/100ps
module abx_exec
  import abx_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  input  wire logic [abx_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [abx_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output logic                          exec_busy
);
  import abx_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  abx_phase_t          ph_r;
  logic                nop_r;
  logic [15:0]         ins_r;
  logic [7:0]          acc_r;
  abx_flags_t          fl_r;
  logic [3:0]          bank_r;
  logic [20:0]         pc_r;
  logic [11:0]         index_r;
  logic                ext_r;
  logic                bad_r;
  logic [11:0]         fa_r;
  logic [7:0]          opnd_r;
  logic [7:0]          res_r;
  abx_flags_t          fres_r;
  logic                take_r;
  logic [7:0]          file_r [FILE_DEPTH];
  logic                aw_got_r;
  logic                w_got_r;
  logic [ADDR_W-1:0]   waddr_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic                rvalid_r;
  logic [1:0]          rresp_r;
  logic [31:0]         rdata_r;

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic [7:0]          ffld;
  logic                dbit;
  logic                abit;
  logic [2:0]          bsel;
  logic                is_addc;
  logic                is_andf;
  logic                is_andl;
  logic                is_brc;
  logic                is_brn;
  logic                is_bclr;
  logic                is_byte;
  logic                is_file;
  logic                is_br;
  logic                q4x;
  logic [FILE_AW-1:0]  fidx;

  assign ffld    = ins_r[7:0];
  assign dbit    = ins_r[9];
  assign abit    = ins_r[8];
  assign bsel    = ins_r[11:9];
  assign is_addc = ins_r[15:10] == OPC_ADDC;
  assign is_andf = ins_r[15:10] == OPC_ANDF;
  assign is_andl = ins_r[15:8] == OPC_ANDL;
  assign is_brc  = ins_r[15:8] == OPC_BRC;
  assign is_brn  = ins_r[15:8] == OPC_BRN;
  assign is_bclr = ins_r[15:12] == OPC_BCLR;
  assign is_byte = is_addc | is_andf;
  assign is_file = is_byte | is_bclr;
  assign is_br   = is_brc | is_brn;
  assign q4x     = (ph_r == PH_WR) && !nop_r;
  assign fidx    = fa_r[FILE_AW-1:0];
  assign exec_busy = ph_r != PH_IDLE;

  // ****************************************************************
  // Data address
  // ****************************************************************
  // Only the low address bits reach the small file store, so banks alias.
  logic [11:0] fa;

  always_comb
  begin
    if (abit)
      fa = {bank_r, ffld}; // RULE5
    else if (ext_r && ffld <= ACC_LIMIT)
      fa = index_r + {4'h0, ffld}; // RULE6
    else if (ffld <= ACC_LIMIT)
      fa = {4'h0, ffld}; // RULE4
    else
      fa = {ACC_HIGH, ffld}; // RULE4
  end

  // ****************************************************************
  // Bus write side
  // ****************************************************************
  logic        wr_fire;
  logic        bus_we;
  logic        go;
  logic [31:0] wnew;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        m[8*i +: 8] = nw[8*i +: 8];
    return m;
  endfunction

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  // Software writes are dropped while an instruction runs, to keep it coherent
  assign bus_we  = wr_fire && (ph_r == PH_IDLE);
  assign go      = bus_we && waddr_r == ADDR_CTRL && wstrb_r[0] && wdata_r[CTRL_GO];

  always_comb
  begin
    wnew = 32'h00000000;
    case (waddr_r)
      ADDR_INSTR: wnew = merge({16'h0000, ins_r}, wdata_r, wstrb_r);
      ADDR_ACC:   wnew = merge({24'h000000, acc_r}, wdata_r, wstrb_r);
      ADDR_FLAGS: wnew = merge({27'h0000000, fl_r}, wdata_r, wstrb_r);
      ADDR_BANK:  wnew = merge({28'h0000000, bank_r}, wdata_r, wstrb_r);
      ADDR_PC:    wnew = merge({11'h000, pc_r}, wdata_r, wstrb_r);
      ADDR_INDEX: wnew = merge({20'h00000, index_r}, wdata_r, wstrb_r);
      default:    wnew = merge({24'h000000, file_r[waddr_r[FILE_AW+1:2]]}, wdata_r, wstrb_r);
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      waddr_r  <= '0;
      wdata_r  <= 32'h00000000;
      wstrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        waddr_r  <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= (waddr_r <= ADDR_STATE || waddr_r[7:6] == FILE_WIN) ?
                    RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Bus read side
  // ****************************************************************
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h00000000;
    end
    else if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h00000000;
      case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
        ADDR_CTRL:  rdata_r[CTRL_EXT] <= ext_r;
        ADDR_INSTR: rdata_r[15:0] <= ins_r;
        ADDR_ACC:   rdata_r[7:0] <= acc_r;
        ADDR_FLAGS: rdata_r[4:0] <= fl_r;
        ADDR_BANK:  rdata_r[3:0] <= bank_r;
        ADDR_PC:    rdata_r[20:0] <= pc_r;
        ADDR_INDEX: rdata_r[11:0] <= index_r;
        ADDR_STATE: rdata_r <= {4'h0, fa_r, 3'h0, ph_r, 6'h00, bad_r, exec_busy};
        default:
        begin
          if (s_axi_araddr[7:6] == FILE_WIN)
            rdata_r[7:0] <= file_r[s_axi_araddr[FILE_AW+1:2]];
          else
            rresp_r <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'b0;
  end

  // ****************************************************************
  // Phase sequencer
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ph_r  <= PH_IDLE;
      nop_r <= 1'b0;
    end
    else
    begin
      case (ph_r)
        PH_IDLE: if (go) ph_r <= PH_DEC; // RULE15
        PH_DEC:  ph_r <= PH_RD;
        PH_RD:   ph_r <= PH_PROC;
        PH_PROC: ph_r <= PH_WR;
        PH_WR:
        begin
          // A taken branch replays the four phases as a dead cycle
          if (!nop_r && take_r)
          begin
            nop_r <= 1'b1; // RULE11
            ph_r  <= PH_DEC;
          end
          else
          begin
            nop_r <= 1'b0;
            ph_r  <= PH_IDLE;
          end
        end
        default: ph_r <= PH_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Operand read and processing
  // ****************************************************************
  logic [8:0] sum9;
  logic [4:0] nib;
  logic [7:0] alu_res;
  abx_flags_t alu_fl;

  assign sum9 = {1'b0, acc_r} + {1'b0, opnd_r} + {8'h00, fl_r.c}; // RULE1
  assign nib  = {1'b0, acc_r[3:0]} + {1'b0, opnd_r[3:0]} + {4'h0, fl_r.c};

  always_comb
  begin
    alu_res = opnd_r;
    alu_fl  = fl_r;
    if (is_addc)
    begin
      alu_res   = sum9[7:0]; // RULE1
      alu_fl.c  = sum9[8]; // RULE14
      alu_fl.half = nib[4];
      alu_fl.wrap = (acc_r[7] == opnd_r[7]) && (sum9[7] != acc_r[7]);
      alu_fl.z  = sum9[7:0] == 8'h00;
      alu_fl.n  = sum9[7];
    end
    else if (is_andf || is_andl)
    begin
      alu_res  = acc_r & opnd_r; // RULE7 RULE8
      alu_fl.z = (acc_r & opnd_r) == 8'h00; // RULE14
      alu_fl.n = acc_r[7] & opnd_r[7];
    end
    else if (is_bclr)
      alu_res = opnd_r & ~(8'h01 << bsel); // RULE12
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      fa_r   <= 12'h000;
      opnd_r <= 8'h00;
      res_r  <= 8'h00;
      fres_r <= RST_FLAGS;
      take_r <= 1'b0;
    end
    else if (!nop_r && ph_r == PH_RD)
    begin
      fa_r   <= fa;
      opnd_r <= is_file ? file_r[fa[FILE_AW-1:0]] : ffld; // RULE15
    end
    else if (!nop_r && ph_r == PH_PROC)
    begin
      res_r  <= alu_res;
      fres_r <= alu_fl;
      take_r <= (is_brc && fl_r.c) || (is_brn && fl_r.n); // RULE9 RULE13
    end
  end

  // ****************************************************************
  // Write-back
  // ****************************************************************
  logic [20:0] target;

  assign target = pc_r + PC_STEP + {{12{ffld[7]}}, ffld, 1'b0}; // RULE10

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      acc_r <= RST_ACC;
    else if (q4x && ((is_byte && !dbit) || is_andl))
      acc_r <= res_r; // RULE2 RULE7
    else if (bus_we && waddr_r == ADDR_ACC)
      acc_r <= wnew[7:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      fl_r <= RST_FLAGS;
    else if (q4x && (is_byte || is_andl))
      fl_r <= fres_r; // RULE14
    else if (bus_we && waddr_r == ADDR_FLAGS)
      fl_r <= wnew[4:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      for (int i = 0; i < FILE_DEPTH; i++)
        file_r[i] <= RST_FILE;
    else if (q4x && ((is_byte && dbit) || is_bclr))
      file_r[fidx] <= res_r; // RULE3 RULE12
    else if (bus_we && waddr_r[7:6] == FILE_WIN)
      file_r[waddr_r[FILE_AW+1:2]] <= wnew[7:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      pc_r <= RST_PC;
    else if (q4x)
      pc_r <= take_r ? target : pc_r + PC_STEP; // RULE10 RULE11
    else if (bus_we && waddr_r == ADDR_PC)
      pc_r <= wnew[20:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ins_r   <= RST_INSTR;
      bank_r  <= RST_BANK;
      index_r <= RST_INDEX;
      ext_r   <= 1'b0;
    end
    else if (bus_we)
    begin
      if (waddr_r == ADDR_INSTR)
        ins_r <= wnew[15:0];
      if (waddr_r == ADDR_BANK)
        bank_r <= wnew[3:0];
      if (waddr_r == ADDR_INDEX)
        index_r <= wnew[11:0];
      if (waddr_r == ADDR_CTRL && wstrb_r[0])
        ext_r <= wdata_r[CTRL_EXT];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      bad_r <= 1'b0;
    else if (q4x)
      bad_r <= !(is_file || is_andl || is_br);
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  add_sum_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE1
    q4x && is_addc |-> res_r == 8'(acc_r + opnd_r + {7'h00, fl_r.c}))
    else $error("carry add result wrong");
  dest_acc_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE2
    q4x && is_byte && !dbit |=> acc_r == $past(res_r) && file_r[fidx] == $past(file_r[fidx]))
    else $error("accumulator destination wrong");
  dest_file_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE3
    q4x && is_byte && dbit |=> file_r[fidx] == $past(res_r) && $stable(acc_r))
    else $error("file destination wrong");
  access_bank_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE4
    ph_r == PH_RD && !abit && !(ext_r && ffld <= ACC_LIMIT)
    |-> fa[7:0] == ffld && (fa[11:8] == 4'h0) == (ffld <= ACC_LIMIT))
    else $error("access bank address wrong");
  bank_sel_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE5
    ph_r == PH_RD && !nop_r && abit |=> fa_r == {bank_r, ffld})
    else $error("banked address wrong");
  index_off_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE6
    ph_r == PH_RD && !nop_r && !abit && ext_r && ffld <= ACC_LIMIT
    |=> fa_r == $past(index_r) + {4'h0, $past(ffld)})
    else $error("indexed address wrong");
  and_lit_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE7
    ph_r == PH_PROC && !nop_r && is_andl |=> ##1 acc_r == ($past(acc_r, 2) & ffld))
    else $error("literal AND wrong");
  and_file_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE8
    q4x && is_andf |-> res_r == (acc_r & opnd_r) && fres_r.c == fl_r.c)
    else $error("file AND wrong");
  carry_clr_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE9
    q4x && is_brc && !fl_r.c |=> pc_r == $past(pc_r) + PC_STEP && ph_r == PH_IDLE)
    else $error("branch on clear carry taken");
  br_target_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE10
    q4x && take_r |=> pc_r == $past(pc_r) + 21'd2 + 21'($signed(ffld)) * 21'd2)
    else $error("branch target wrong");
  br_cycles_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE11
    q4x && take_r |=> nop_r [*4] ##1 (ph_r == PH_IDLE && !nop_r && $stable(pc_r)))
    else $error("taken branch timing wrong");
  bit_clr_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE12
    q4x && is_bclr |=> file_r[fidx][$past(bsel)] == 1'b0 && $stable(fl_r))
    else $error("bit clear wrong");
  neg_br_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE13
    q4x && is_brn |-> take_r == fl_r.n)
    else $error("negative branch decision wrong");
  flags_kept_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE14
    q4x && (is_br || is_bclr) |=> $stable(fl_r))
    else $error("flags changed by branch or bit clear");
  four_phase_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE15
    go |=> ph_r == PH_DEC ##1 ph_r == PH_RD ##1 ph_r == PH_PROC ##1 ph_r == PH_WR)
    else $error("phase order wrong");
endmodule

// ---- src/abx_pkg.sv ----
// Constants, types and register map of the add-and-branch execution block.
// Assumes one 100 MHz clock and an AXI4-Lite master on the same clock.
package abx_pkg;
  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int         ADDR_W      = 8;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_INSTR  = 8'h04;
  localparam logic [7:0] ADDR_ACC    = 8'h08;
  localparam logic [7:0] ADDR_FLAGS  = 8'h0C;
  localparam logic [7:0] ADDR_BANK   = 8'h10;
  localparam logic [7:0] ADDR_PC     = 8'h14;
  localparam logic [7:0] ADDR_INDEX  = 8'h18;
  localparam logic [7:0] ADDR_STATE  = 8'h1C;
  localparam logic [1:0] FILE_WIN    = 2'h1;
  localparam int         FILE_AW     = 4;
  localparam int         FILE_DEPTH  = 16;
  localparam int         CTRL_GO     = 0;
  localparam int         CTRL_EXT    = 1;
  localparam int         ST_BUSY     = 0;
  localparam int         ST_BAD      = 1;
  localparam int         ST_PH_LO    = 8;
  localparam int         ST_ADDR_LO  = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Instruction encodings and addressing
  // ****************************************************************
  localparam logic [5:0] OPC_ADDC    = 6'h08;
  localparam logic [5:0] OPC_ANDF    = 6'h05;
  localparam logic [7:0] OPC_ANDL    = 8'h0B;
  localparam logic [7:0] OPC_BRC     = 8'hE2;
  localparam logic [7:0] OPC_BRN     = 8'hE6;
  localparam logic [3:0] OPC_BCLR    = 4'h9;
  localparam logic [7:0] ACC_LIMIT   = 8'h5F;
  localparam logic [3:0] ACC_HIGH    = 4'hF;
  localparam logic [20:0] PC_STEP    = 21'h000002;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  RST_ACC    = 8'h00;
  localparam logic [15:0] RST_INSTR  = 16'h0000;
  localparam logic [3:0]  RST_BANK   = 4'h0;
  localparam logic [20:0] RST_PC     = 21'h000000;
  localparam logic [11:0] RST_INDEX  = 12'h000;
  localparam logic [7:0]  RST_FILE   = 8'h00;

  typedef struct packed {
    logic n;
    logic wrap;
    logic z;
    logic half;
    logic c;
  } abx_flags_t;

  localparam abx_flags_t RST_FLAGS = 5'h00;

  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_DEC  = 5'b00010,
    PH_RD   = 5'b00100,
    PH_PROC = 5'b01000,
    PH_WR   = 5'b10000
  } abx_phase_t;
endpackage

// ---- verification/cpu_add_and_branch_exec_test.sv ----
// Self-checking bench for the add-and-branch execution unit.
// Assumes abx_exec and abx_pkg; the bench is the only AXI4-Lite master.
`timescale 1ns/100ps
module cpu_add_and_branch_exec_test;
  import abx_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        ref_clk     = 1'b0;
  logic        reset       = 1'b1;
  logic [7:0]  awaddr      = 8'h00;
  logic        awvalid     = 1'b0;
  logic        awready;
  logic [31:0] wdata       = 32'h0;
  logic        wvalid      = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready      = 1'b0;
  logic [7:0]  araddr      = 8'h00;
  logic        arvalid     = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready      = 1'b0;
  logic        exec_busy;
  logic [31:0] rdat;
  logic [1:0]  resp_q;
  int          errors      = 0;
  int          comparisons = 0;
  int          busy_cnt    = 0;

  always #5 ref_clk = ~ref_clk;
  // Counted at the falling edge so the phase register has settled
  always @(negedge ref_clk) if (exec_busy === 1'b1) busy_cnt++;

  abx_exec i_dut
  (
    .ref_clk       (ref_clk),
    .reset         (reset),
    .s_axi_awaddr  (awaddr),
    .s_axi_awvalid (awvalid),
    .s_axi_awready (awready),
    .s_axi_wdata   (wdata),
    .s_axi_wstrb   (4'hF),
    .s_axi_wvalid  (wvalid),
    .s_axi_wready  (wready),
    .s_axi_bresp   (bresp),
    .s_axi_bvalid  (bvalid),
    .s_axi_bready  (bready),
    .s_axi_araddr  (araddr),
    .s_axi_arvalid (arvalid),
    .s_axi_arready (arready),
    .s_axi_rdata   (rdata),
    .s_axi_rresp   (rresp),
    .s_axi_rvalid  (rvalid),
    .s_axi_rready  (rready),
    .exec_busy     (exec_busy)
  );

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic close_out();
    $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic give_up();
    chk(32'h0, 32'h1);
    close_out();
  endtask

  // Readies are sampled at the falling edge; the take is the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_p = 1'b1;
    bit w_p  = 1'b1;
    bit aw_t;
    bit w_t;
    int n    = 0;
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (aw_p || w_p)
    begin
      @(negedge ref_clk);
      if (++n > 40) give_up();
      aw_t = aw_p && (awready === 1'b1);
      w_t  = w_p && (wready === 1'b1);
      @(posedge ref_clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      aw_p = aw_p && !aw_t;
      w_p  = w_p && !w_t;
    end
    do
    begin
      @(negedge ref_clk);
      if (++n > 40) give_up();
    end
    while (bvalid !== 1'b1);
    resp_q = bresp;
    @(posedge ref_clk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int n = 0;
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(negedge ref_clk);
      if (++n > 40) give_up();
    end
    while (arready !== 1'b1);
    @(posedge ref_clk);
    arvalid <= 1'b0;
    do
    begin
      @(negedge ref_clk);
      if (++n > 40) give_up();
    end
    while (rvalid !== 1'b1);
    rdat   = rdata;
    resp_q = rresp;
    @(posedge ref_clk);
    rready <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdat, exp);
  endtask

  task automatic chk_addr(input logic [11:0] exp);
    rd(ADDR_STATE);
    chk({20'h0, rdat[27:16]}, {20'h0, exp});
  endtask

  task automatic run(input logic [15:0] ins, input logic ext, input int cyc);
    int n = 0;
    wr(ADDR_INSTR, {16'h0, ins});
    busy_cnt = 0;
    wr(ADDR_CTRL, {30'h0, ext, 1'b1});
    do
    begin
      @(negedge ref_clk);
      if (++n > 40) give_up();
    end
    while (exec_busy !== 1'b0);
    chk(busy_cnt, cyc);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    chk_rd(ADDR_ACC, 32'h0);
    chk_rd(ADDR_FLAGS, 32'h0);
    chk_rd(ADDR_STATE, {19'h0, PH_IDLE, 8'h00});
    // An unknown opcode only steps the program counter and flags itself
    run(16'hFFFF, 1'b0, 4);
    rd(ADDR_STATE);
    chk({31'h0, rdat[ST_BAD]}, 32'h1);
    chk_rd(ADDR_PC, 32'h2);
    chk_rd(ADDR_ACC, 32'h0);
    rd(8'h30);
    chk({30'h0, resp_q}, {30'h0, RESP_SLVERR});
    wr(8'h34, 32'h5A);
    chk({30'h0, resp_q}, {30'h0, RESP_SLVERR});
    $display("Reset and unmapped test done");
  endtask

  task automatic t_add();
    wr(ADDR_ACC, 32'h4D);
    wr(8'h4C, 32'h02);
    wr(ADDR_FLAGS, 32'h01);
    wr(ADDR_PC, 32'h40);
    run(16'h2063, 1'b0, 4);
    chk_rd(ADDR_ACC, 32'h50);
    chk_rd(8'h4C, 32'h02);
    chk_rd(ADDR_FLAGS, 32'h02);
    chk_rd(ADDR_PC, 32'h42);
    chk_addr(12'hF63);
    // Both operands negative with carry in: signed wrap and carry out
    wr(ADDR_ACC, 32'h80);
    wr(8'h54, 32'h80);
    wr(ADDR_FLAGS, 32'h01);
    wr(ADDR_BANK, 32'h2);
    run(16'h2305, 1'b1, 4);
    chk_rd(8'h54, 32'h01);
    chk_rd(ADDR_ACC, 32'h80);
    chk_rd(ADDR_FLAGS, 32'h09);
    chk_addr(12'h205);
    $display("Add with carry test done");
  endtask

  task automatic t_and();
    wr(ADDR_ACC, 32'hA3);
    wr(ADDR_FLAGS, 32'h0B);
    run(16'h0B5F, 1'b0, 4);
    chk_rd(ADDR_ACC, 32'h03);
    chk_rd(ADDR_FLAGS, 32'h0B);
    wr(ADDR_ACC, 32'h80);
    wr(8'h48, 32'hC2);
    run(16'h1662, 1'b0, 4);
    chk_rd(8'h48, 32'h80);
    chk_rd(ADDR_FLAGS, 32'h1B);
    wr(ADDR_ACC, 32'h0F);
    run(16'h1462, 1'b0, 4);
    chk_rd(ADDR_ACC, 32'h00);
    chk_rd(8'h48, 32'h80);
    chk_rd(ADDR_FLAGS, 32'h0F);
    $display("AND test done");
  endtask

  task automatic t_branch();
    logic [7:0]  opc [5] = '{OPC_BRC, OPC_BRC, OPC_BRN, OPC_BRN, OPC_BRN};
    logic [4:0]  fl  [5] = '{5'h01, 5'h1E, 5'h10, 5'h0F, 5'h1F};
    logic [7:0]  off [5] = '{8'h05, 8'h05, 8'h80, 8'h80, 8'h7F};
    logic [31:0] pc  [5] = '{32'h100C, 32'h1002, 32'h0F02, 32'h1002, 32'h1100};
    int          cy  [5] = '{8, 4, 8, 4, 8};
    for (int i = 0; i < 5; i++)
    begin
      wr(ADDR_FLAGS, {27'h0, fl[i]});
      wr(ADDR_PC, 32'h1000);
      run({opc[i], off[i]}, 1'b0, cy[i]);
      chk_rd(ADDR_PC, pc[i]);
      chk_rd(ADDR_FLAGS, {27'h0, fl[i]});
    end
    $display("Branch test done");
  endtask

  task automatic t_bit_ext();
    wr(ADDR_FLAGS, 32'h1F);
    wr(8'h5C, 32'hC7);
    run(16'h9E67, 1'b0, 4);
    chk_rd(8'h5C, 32'h47);
    chk_rd(ADDR_FLAGS, 32'h1F);
    // Indexed window ends at 5Fh; 60h must fall back to the access bank
    wr(ADDR_INDEX, 32'h123);
    wr(8'h48, 32'hFF);
    wr(8'h40, 32'hFF);
    run(16'h905F, 1'b1, 4);
    chk_addr(12'h182);
    chk_rd(8'h48, 32'hFE);
    run(16'h9060, 1'b1, 4);
    chk_addr(12'hF60);
    chk_rd(ADDR_CTRL, 32'h2);
    run(16'h9210, 1'b0, 4);
    chk_addr(12'h010);
    chk_rd(8'h40, 32'hFC);
    $display("Bit clear and addressing test done");
  endtask

  initial
  begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_add();
    t_and();
    t_branch();
    t_bit_ext();
    close_out();
  end
endmodule
